// File: hdl/pia_pkg.sv
package pia_pkg;

    // ----------------------------------------------------------------
    // sizes and encodings
    // ----------------------------------------------------------------
    localparam int NUM_SRC      = 32;
    localparam int NUM_PERIPH   = 30;
    localparam int IDX_W        = 5;
    localparam int ID_W         = 6;
    localparam int PRIO_W       = 5;
    localparam int SW_SRC_IDX   = 30;
    localparam int TMR_SRC_IDX  = 31;

    localparam logic [ID_W-1:0]    ID_NONE    = 6'h00;
    localparam logic [ID_W-1:0]    ID_BASE    = 6'h01;
    localparam logic [PRIO_W-1:0]  PRIO_NONE  = 5'h00;
    localparam logic [NUM_SRC-1:0] MASK_RESET = 32'h0000_0000;

    typedef logic [NUM_SRC-1:0][PRIO_W-1:0] prio_arr_t;
    typedef logic [NUM_SRC-1:0]             src_vec_t;

    // request or completion: valid plus source identifier
    typedef struct packed {
        logic            vld;
        logic [ID_W-1:0] id;
    } irq_req_s;

    // arbitration outcome
    typedef struct packed {
        logic              vld;
        logic [IDX_W-1:0]  idx;
        logic [PRIO_W-1:0] prio;
    } arb_s;

    localparam irq_req_s REQ_IDLE = '{vld: 1'b0, id: ID_NONE};

    // ----------------------------------------------------------------
    // highest priority among masked sources strictly above floor;
    // scanning upward with a strict compare keeps the lower index on a tie
    // ----------------------------------------------------------------
    function automatic arb_s arbitrate(input src_vec_t mask, input prio_arr_t prio,
                                       input logic [PRIO_W-1:0] floor_prio);
        arb_s res;
        res = '{vld: 1'b0, idx: '0, prio: PRIO_NONE};
        for (int i = 0; i < NUM_SRC; i++) begin
            if (mask[i] && prio[i] > floor_prio && (!res.vld || prio[i] > res.prio)) begin
                res.vld  = 1'b1;
                res.idx  = IDX_W'(i);
                res.prio = prio[i];
            end
        end
        return res;
    endfunction

    function automatic src_vec_t onehot(input logic [IDX_W-1:0] idx);
        src_vec_t v;
        v      = '0;
        v[idx] = 1'b1;
        return v;
    endfunction

    function automatic logic [ID_W-1:0] idx_to_id(input logic [IDX_W-1:0] idx);
        return {1'b0, idx} + ID_BASE;
    endfunction

endpackage

// File: hdl/platform_interrupt_arbiter.sv
`timescale 1ns/100ps
// Overview of operation
// - thirty-two independent source lines, each ranked in the arbitration of the one target DELEG_IN selects.
// - source identifiers start at 1; identifier 0 means no request or completion.
// - each source has a 5-bit priority, 31 most urgent, sharing allowed.
// - among equal priorities the smaller identifier wins.
// - a source is forwarded only with its enable set.
// - a programmable threshold withholds sources that do not clear it.
// - each dispatch is a request pulse of exactly one clock.
// - at most one request at a time, machine target first, each target's highest-ranked eligible source.
// - a source in service is not dispatched again.
// - a rising edge on a source sets its pending flag.
// - every request carries the dispatched source identifier for vectoring.
// - higher priority preempts a handler; core disables nesting during context save.
// - peripheral, software and timer interrupts are arbitrated together.
// - machine and supervisor targets, with per-source delegation to supervisor.
module platform_interrupt_arbiter (
    input  wire logic                           REF_CLK_IN,
    input  wire logic                           NRST_IN,
    input  wire logic [pia_pkg::NUM_PERIPH-1:0] PERIPH_IRQ_IN,
    input  wire logic                           SW_IRQ_IN,
    input  wire logic                           TMR_IRQ_IN,
    input  wire pia_pkg::src_vec_t              SRC_EN_IN,
    input  wire pia_pkg::src_vec_t              DELEG_IN,
    input  wire pia_pkg::prio_arr_t             PRIO_IN,
    input  wire logic [pia_pkg::PRIO_W-1:0]     M_THRESH_IN,
    input  wire logic [pia_pkg::PRIO_W-1:0]     S_THRESH_IN,
    input  wire logic                           NEST_EN_IN,
    input  wire pia_pkg::irq_req_s              CMPL_IN,
    output pia_pkg::irq_req_s                   M_REQ_OUT,
    output pia_pkg::irq_req_s                   S_REQ_OUT,
    output pia_pkg::src_vec_t                   PEND_OUT,
    output pia_pkg::src_vec_t                   ISV_OUT
);
    import pia_pkg::*;

    // ----------------------------------------------------------------
    // source sampling
    // ----------------------------------------------------------------
    logic [NUM_PERIPH-1:0] meta_q;
    logic [NUM_PERIPH-1:0] sync_q;
    src_vec_t              prev_q;
    src_vec_t              src_now;
    src_vec_t              rise;

    // peripheral lines are asynchronous; software and timer lines share our clock
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= PERIPH_IRQ_IN;
            sync_q <= meta_q;
        end
    end

    assign src_now = {TMR_IRQ_IN, SW_IRQ_IN, sync_q};
    assign rise    = src_now & ~prev_q;

    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            prev_q <= MASK_RESET;
        end else begin
            prev_q <= src_now;
        end
    end

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    src_vec_t          pend_q;
    src_vec_t          pend_d;
    src_vec_t          isv_q;
    src_vec_t          isv_d;
    src_vec_t          isv_s_q;
    src_vec_t          isv_s_d;
    src_vec_t          ready;
    src_vec_t          m_mask;
    src_vec_t          s_mask;
    arb_s              m_isv;
    arb_s              s_isv;
    arb_s              m_win;
    arb_s              s_win;
    logic [PRIO_W-1:0] m_floor;
    logic [PRIO_W-1:0] s_floor;
    logic              m_block;
    logic              s_block;
    logic              m_go;
    logic              s_go;
    src_vec_t          m_hit;
    src_vec_t          s_hit;
    src_vec_t          go_mask;
    src_vec_t          cmpl_mask;
    logic              cmpl_ok;
    irq_req_s          m_req_d;
    irq_req_s          s_req_d;

    assign ready  = pend_q & ~isv_q & SRC_EN_IN;
    assign m_mask = ready & ~DELEG_IN;
    assign s_mask = ready & DELEG_IN;

    // highest priority still in service per target; priority 0 never enters service
    assign m_isv  = arbitrate(isv_q & ~isv_s_q, PRIO_IN, PRIO_NONE);
    assign s_isv  = arbitrate(isv_q & isv_s_q, PRIO_IN, PRIO_NONE);

    // preemption needs priority above the running handler
    assign m_floor = (m_isv.vld && m_isv.prio > M_THRESH_IN) ? m_isv.prio : M_THRESH_IN;
    assign s_floor = (s_isv.vld && s_isv.prio > S_THRESH_IN) ? s_isv.prio : S_THRESH_IN;
    // core holds nesting off while saving context
    assign m_block = m_isv.vld & ~NEST_EN_IN;
    assign s_block = s_isv.vld & ~NEST_EN_IN;

    // lower index kept on a tie
    assign m_win = arbitrate(m_mask, PRIO_IN, m_floor);
    assign s_win = arbitrate(s_mask, PRIO_IN, s_floor);

    // machine target first, supervisor only in a cycle with no machine dispatch
    assign m_go  = m_win.vld & ~m_block;
    assign s_go  = s_win.vld & ~s_block & ~m_go;
    assign m_hit = m_go ? onehot(m_win.idx) : MASK_RESET;
    assign s_hit = s_go ? onehot(s_win.idx) : MASK_RESET;
    assign go_mask = m_hit | s_hit;

    assign cmpl_ok   = CMPL_IN.vld && CMPL_IN.id != ID_NONE && CMPL_IN.id <= ID_W'(NUM_SRC);
    assign cmpl_mask = cmpl_ok ? onehot(IDX_W'(CMPL_IN.id - ID_BASE)) : MASK_RESET;

    // a new edge wins over the dispatch clear
    assign pend_d  = (pend_q & ~go_mask) | rise;
    // completion frees the source for its next edge
    assign isv_d   = (isv_q & ~cmpl_mask) | go_mask;
    assign isv_s_d = (isv_s_q & ~cmpl_mask) | s_hit;

    assign m_req_d = m_go ? '{vld: 1'b1, id: idx_to_id(m_win.idx)} : REQ_IDLE;
    assign s_req_d = s_go ? '{vld: 1'b1, id: idx_to_id(s_win.idx)} : REQ_IDLE;

    // ----------------------------------------------------------------
    // state and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pend_q  <= MASK_RESET;
            isv_q   <= MASK_RESET;
            isv_s_q <= MASK_RESET;
        end else begin
            pend_q  <= pend_d;
            isv_q   <= isv_d;
            isv_s_q <= isv_s_d;
        end
    end

    // request registers hold one dispatch per cycle
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            M_REQ_OUT <= REQ_IDLE;
            S_REQ_OUT <= REQ_IDLE;
            PEND_OUT  <= MASK_RESET;
            ISV_OUT   <= MASK_RESET;
        end else begin
            M_REQ_OUT <= m_req_d;
            S_REQ_OUT <= s_req_d;
            PEND_OUT  <= pend_d;
            ISV_OUT   <= isv_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    src_vec_t m_tie_lo;
    src_vec_t m_above;
    src_vec_t s_tie_lo;
    src_vec_t s_above;

    // check helpers only: equal priority below the winner, or strictly above it
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_rank
        assign m_tie_lo[g] = m_mask[g] && PRIO_IN[g] == m_win.prio && g < m_win.idx;
        assign m_above[g]  = m_mask[g] && PRIO_IN[g] > m_win.prio;
        assign s_tie_lo[g] = s_mask[g] && PRIO_IN[g] == s_win.prio && g < s_win.idx;
        assign s_above[g]  = s_mask[g] && PRIO_IN[g] > s_win.prio;
    end

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!NRST_IN);

    sequence dispatch_m;
        m_go;
    endsequence

    sequence pulse_m(logic [ID_W-1:0] want);
        M_REQ_OUT.vld && M_REQ_OUT.id == want;
    endsequence

    sequence dispatch_s;
        s_go;
    endsequence

    sequence pulse_s(logic [ID_W-1:0] want);
        S_REQ_OUT.vld && S_REQ_OUT.id == want;
    endsequence

    chk_req_id_pulse: assert property (
        dispatch_m |=> pulse_m(idx_to_id($past(m_win.idx))))
        else $error("machine request lacks the dispatched identifier");

    chk_req_one_cycle: assert property (
        M_REQ_OUT.vld |=> !(M_REQ_OUT.vld && M_REQ_OUT.id == $past(M_REQ_OUT.id)))
        else $error("machine request held longer than one cycle");

    chk_single_req: assert property (
        !(M_REQ_OUT.vld && S_REQ_OUT.vld))
        else $error("two requests presented at once");

    chk_idle_id_zero: assert property (
        (!M_REQ_OUT.vld |-> M_REQ_OUT.id == ID_NONE) and (!S_REQ_OUT.vld |-> S_REQ_OUT.id == ID_NONE))
        else $error("idle request shows a non-zero identifier");

    chk_edge_sets: assert property (
        1'b1 |=> ($past(rise) & ~pend_q) == MASK_RESET)
        else $error("rising edge failed to set pending");

    chk_isv_no_repeat: assert property (
        dispatch_m |-> !isv_q[m_win.idx] ##1 isv_q[$past(m_win.idx)])
        else $error("source dispatched while in service");

    chk_above_thresh: assert property (
        dispatch_m |-> m_win.prio > M_THRESH_IN && SRC_EN_IN[m_win.idx])
        else $error("dispatch not above threshold or not enabled");

    chk_deleg_target: assert property (
        (s_go |-> DELEG_IN[s_win.idx]) and (m_go |-> !DELEG_IN[m_win.idx]))
        else $error("source sent to the wrong privilege target");

    chk_nest_block: assert property (
        m_isv.vld && !NEST_EN_IN |-> !m_go ##1 !M_REQ_OUT.vld)
        else $error("dispatch while nesting disabled");

    chk_cmpl_clears: assert property (
        cmpl_ok && (cmpl_mask & go_mask) == MASK_RESET |=> !isv_q[IDX_W'($past(CMPL_IN.id) - ID_BASE)])
        else $error("completion left source in service");

    chk_s_req_id: assert property (
        dispatch_s |=> pulse_s(idx_to_id($past(s_win.idx))))
        else $error("supervisor request lacks the dispatched identifier");

    chk_s_one_cycle: assert property (
        S_REQ_OUT.vld |=> !(S_REQ_OUT.vld && S_REQ_OUT.id == $past(S_REQ_OUT.id)))
        else $error("supervisor request held longer than one cycle");

    chk_s_above_thresh: assert property (
        dispatch_s |-> s_win.prio > S_THRESH_IN && SRC_EN_IN[s_win.idx])
        else $error("supervisor dispatch not above threshold or not enabled");

    chk_s_no_repeat: assert property (
        dispatch_s |-> !isv_q[s_win.idx] ##1 isv_q[$past(s_win.idx)])
        else $error("supervisor source dispatched while in service");

    chk_s_nest_block: assert property (
        s_isv.vld && !NEST_EN_IN |-> !s_go ##1 !S_REQ_OUT.vld)
        else $error("supervisor dispatch while nesting disabled");

    chk_highest_wins: assert property (
        (dispatch_m |-> m_above == MASK_RESET) and (dispatch_s |-> s_above == MASK_RESET))
        else $error("a higher-priority eligible source was passed over");

    chk_tie_lower_id: assert property (
        (dispatch_m |-> m_tie_lo == MASK_RESET) and (dispatch_s |-> s_tie_lo == MASK_RESET))
        else $error("tie not resolved to the smaller identifier");

    chk_prio_zero_idle: assert property (
        (m_go |-> PRIO_IN[m_win.idx] != PRIO_NONE) and (s_go |-> PRIO_IN[s_win.idx] != PRIO_NONE))
        else $error("priority-zero source dispatched");

    chk_one_dispatch: assert property (
        $onehot0(go_mask))
        else $error("more than one source dispatched in a cycle");

    chk_no_stray_clear: assert property (
        !cmpl_ok |=> ($past(isv_q) & ~isv_q) == MASK_RESET)
        else $error("source left service without a completion");

    chk_cmpl_zero_ignored: assert property (
        CMPL_IN.vld && CMPL_IN.id == ID_NONE |-> cmpl_mask == MASK_RESET)
        else $error("completion with identifier zero was decoded");

    chk_pend_only: assert property (
        (go_mask & ~pend_q) == MASK_RESET)
        else $error("dispatch of a source that was not pending");

    chk_out_mirror: assert property (
        PEND_OUT == pend_q && ISV_OUT == isv_q)
        else $error("status outputs differ from internal state");

endmodule

// File: testbench/core_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// core side: takes requests, saves context, completes handlers
// ----------------------------------------------------------------
module core_model (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire pia_pkg::irq_req_s m_req_in,
    input  wire pia_pkg::irq_req_s s_req_in,
    input  wire logic              auto_in,
    output pia_pkg::irq_req_s      cmpl_out,
    output logic                   nest_en_out
);
    import pia_pkg::*;
    logic [ID_W-1:0] stk[$];
    int              sv;
    int              dl;
    assign nest_en_out = (sv == 0);
    // negedge keeps our edits clear of the arbiter's sampling edge
    // take and complete
    always @(negedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stk.delete();
            sv = 0;
            dl = 0;
            cmpl_out <= REQ_IDLE;
        end else begin
            cmpl_out <= REQ_IDLE;
            if (m_req_in.vld || s_req_in.vld) begin
                stk.push_back(m_req_in.vld ? m_req_in.id : s_req_in.id);
                sv = 2;
                dl = $urandom_range(0, 5);
            end else if (sv != 0) sv--;
            else if (dl != 0) dl--;
            else if (auto_in && stk.size() != 0) cmpl_out <= '{vld: 1'b1, id: stk.pop_back()};
        end
    end
endmodule

// File: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import pia_pkg::*;
    logic              REF_CLK_IN;
    logic              NRST_IN;
    logic              auto;
    logic              nest;
    src_vec_t          src, en, deleg, pend, isv, m, e;
    prio_arr_t         prio;
    logic [PRIO_W-1:0] mthr, sthr;
    irq_req_s          cmpl, mreq, sreq;
    int                n_errors, tests_run;

    platform_interrupt_arbiter platform_interrupt_arbiter_i (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN),
        .PERIPH_IRQ_IN(src[29:0]), .SW_IRQ_IN(src[30]), .TMR_IRQ_IN(src[31]), .SRC_EN_IN(en),
        .DELEG_IN(deleg), .PRIO_IN(prio), .M_THRESH_IN(mthr), .S_THRESH_IN(sthr), .NEST_EN_IN(nest),
        .CMPL_IN(cmpl), .M_REQ_OUT(mreq), .S_REQ_OUT(sreq), .PEND_OUT(pend), .ISV_OUT(isv));
    core_model core_model_i (.clk_in(REF_CLK_IN), .rst_n_in(NRST_IN), .m_req_in(mreq), .s_req_in(sreq),
        .auto_in(auto), .cmpl_out(cmpl), .nest_en_out(nest));

    initial begin
        REF_CLK_IN = 1'b0;
        forever #5 REF_CLK_IN = ~REF_CLK_IN;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic results();
        $display("errors=%0d compares=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_id(input logic [ID_W-1:0] got, input logic [ID_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // lower id wins a tie: scan down, take equal too
    function automatic logic [ID_W-1:0] best(input src_vec_t v, input logic [PRIO_W-1:0] t);
        logic [ID_W-1:0]   id;
        logic [PRIO_W-1:0] bp;
        id = '0;
        bp = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i] && prio[i] > t && (id == '0 || prio[i] >= bp)) begin
                id = ID_W'(i + 1);
                bp = prio[i];
            end
        end
        return id;
    endfunction

    // first pulse within 60 cycles must carry exp; none expected when exp is 0
    task automatic wait_req(input logic tgt, input logic [ID_W-1:0] exp);
        irq_req_s r;
        r = REQ_IDLE;
        for (int k = 0; k < 60 && r.vld !== 1'b1; k++) begin
            @(negedge REF_CLK_IN);
            r = tgt ? sreq : mreq;
        end
        cmp_id(r.id, exp);
        @(negedge REF_CLK_IN);
        cmp(tgt ? sreq : mreq, REQ_IDLE);
    endtask

    // low long enough for the 2-flop sync, then high
    task automatic pulse(input src_vec_t v);
        src = src & ~v;
        repeat (3) @(negedge REF_CLK_IN);
        src = src | v;
    endtask

    task automatic setup();
        en = '1;
        deleg = '0;
        mthr = '0;
        sthr = '0;
        auto = 1'b1;
        prio = {NUM_SRC{5'h01}};
    endtask

    task automatic drain();
        setup();
        repeat (400) @(negedge REF_CLK_IN);
    endtask

    initial begin
        #300_000;
        n_errors++;
        results();
    end

    initial begin
        NRST_IN = 1'b0;
        src = '0;
        prio = '0;
        void'($urandom(83));
        setup();
        repeat (20) @(negedge REF_CLK_IN);
        NRST_IN = 1'b1;
        // ----------------------------------------------------------------
        // every source alone, peripherals, software and timer
        // ----------------------------------------------------------------
        for (int i = 0; i < NUM_SRC; i++) begin
            prio[i] = PRIO_W'($urandom_range(1, 31));
            pulse(src_vec_t'(1) << i);
            wait_req(1'b0, ID_W'(i + 1));
        end
        prio[3] = 5'h00;
        pulse(32'h0000_0008);
        wait_req(1'b0, ID_NONE);
        // ----------------------------------------------------------------
        // random pending sets; round 0 is an all-equal tie
        // ----------------------------------------------------------------
        for (int r = 0; r < 24; r++) begin
            drain();
            en = '0;
            m = $urandom();
            for (int i = 0; i < NUM_SRC; i++) prio[i] = (r == 0) ? 5'h07 : PRIO_W'($urandom());
            mthr = (r < 2) ? 5'h00 : PRIO_W'($urandom_range(0, 12));
            pulse(m);
            repeat (4) @(negedge REF_CLK_IN);
            cmp(pend, m);
            e = (r < 2) ? '1 : src_vec_t'($urandom());
            en = e;
            wait_req(1'b0, best(m & e, mthr));
        end
        // ----------------------------------------------------------------
        // in service, preemption, completion
        // ----------------------------------------------------------------
        drain();
        auto = 1'b0;
        prio[0] = 5'h05;
        prio[1] = 5'h0A;
        prio[2] = 5'h03;
        pulse(32'h0000_0001);
        wait_req(1'b0, 6'h01);
        pulse(32'h0000_0001);
        wait_req(1'b0, ID_NONE);
        pulse(32'h0000_0002);
        wait_req(1'b0, 6'h02);
        cmp(isv, 32'h0000_0003);
        pulse(32'h0000_0004);
        wait_req(1'b0, ID_NONE);
        auto = 1'b1;
        wait_req(1'b0, 6'h01);
        cmp(isv, 32'h0000_0001);
        // ----------------------------------------------------------------
        // supervisor delegation and its threshold
        // ----------------------------------------------------------------
        drain();
        deleg = 32'h0000_0020;
        prio[5] = 5'h09;
        pulse(32'h0000_0020);
        wait_req(1'b1, 6'h06);
        sthr = 5'h09;
        pulse(32'h0000_0020);
        wait_req(1'b1, ID_NONE);
        results();
    end
endmodule
